// file: logic/pcf_pkg.sv
/*
  Package for the program counter and fetch address block: counter widths,
  vectors, register offsets, reset values and the carrier structs.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package pcf_pkg;

  // --------------------------------------------------------------------
  // Widths and sizes
  // --------------------------------------------------------------------
  localparam int unsigned PCF_PC_W    = 21;             // Counter width
  localparam int unsigned PCF_BYTE_W  = 8;              // Register width
  localparam int unsigned PCF_UPPER_W = 5;              // Upper byte bits
  localparam int unsigned PCF_SP_W    = 5;              // Stack pointer width
  localparam int unsigned PCF_ADDR_W  = 4;              // Register address width

  // --------------------------------------------------------------------
  // Vectors and step
  // --------------------------------------------------------------------
  localparam logic [20:0] PCF_RESET_VEC  = 21'h00_0000; // Reset vector
  localparam logic [20:0] PCF_HIGH_VEC   = 21'h00_0008; // High-priority vector
  localparam logic [20:0] PCF_LOW_VEC    = 21'h00_0018; // Low-priority vector
  localparam logic [20:0] PCF_STEP       = 21'h00_0002; // One instruction word
  localparam logic [20:0] PCF_IMPL_LIMIT = 21'h01_8000; // Implemented bytes, default

  // --------------------------------------------------------------------
  // Register offsets (word index on the plain register port)
  // --------------------------------------------------------------------
  localparam logic [3:0] PCF_OFS_PC_LOW   = 4'h0;       // Low counter byte
  localparam logic [3:0] PCF_OFS_LAT_HIGH = 4'h1;       // High latch
  localparam logic [3:0] PCF_OFS_LAT_UP   = 4'h2;       // Upper latch
  localparam logic [3:0] PCF_OFS_TOS_LOW  = 4'h3;       // Top of stack low
  localparam logic [3:0] PCF_OFS_TOS_HIGH = 4'h4;       // Top of stack high
  localparam logic [3:0] PCF_OFS_TOS_UP   = 4'h5;       // Top of stack upper
  localparam logic [3:0] PCF_OFS_SP       = 4'h6;       // Return stack pointer

  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] PCF_LAT_RST = 8'h00;           // Latches after reset
  localparam logic [4:0] PCF_SP_RST  = 5'h00;           // Pointer after reset

  // --------------------------------------------------------------------
  // Carrier structs
  // --------------------------------------------------------------------
  typedef struct packed {
    logic        wr;        // Write strobe
    logic        rd;        // Read strobe
    logic [3:0]  addr;      // Register index
    logic [7:0]  wdata;     // Write data
  } pcf_reg_req_t;

  typedef struct packed {
    logic        branch;    // Direct load from instruction
    logic [20:0] target;    // Branch target
    logic        advance;   // Step to next word
  } pcf_seq_t;

endpackage : pcf_pkg

`default_nettype wire

// file: logic/pcf_core.sv
/*
  Program counter and instruction fetch address generator.
  Assumes a core that issues sequential advances, branch loads and wake
  events synchronous to clk, and a program memory on its own bus that
  answers the fetch address with instruction data in the same cycle.
*/
// Summary of operation
// - 21-bit counter spans 2-Mbyte program space
// - Fetch beyond implemented memory returns zeros
// - Vectors: reset 0000h, interrupts 0008h, 0018h
// - Program fetch bus separate from data
// - Low byte readable/writable; three byte split
// - High byte changed only via latch
// - Upper byte changed only via latch
// - Low byte write copies latches into counter
// - Low byte read copies counter into latches
// - Low byte bit zero always zero
// - Sequential advance adds two
// - Branches load directly, latches ignored
// - Interrupt wake-up loads level vector
// - Wake-up pushes counter, advances stack pointer
// - Push increments pointer, then stores counter
`timescale 1ns/100ps
`default_nettype none

module pcf_core
  import pcf_pkg::*;
#(
  parameter logic [20:0] IMPL_LIMIT = PCF_IMPL_LIMIT  // Implemented size, bytes
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Sequencing from the core
  input  wire logic        seq_advance,
  input  wire logic        seq_branch,
  input  wire logic [20:0] seq_target,
  // Wake-up by interrupt
  input  wire logic        wake_int,
  input  wire logic        wake_high,
  input  wire logic        high_priority_global_int_enable,
  input  wire logic        low_priority_global_int_enable,
  // Program memory bus
  output logic      [20:0] fetch_addr,
  input  wire logic [15:0] prog_rdata,
  output logic      [15:0] fetch_instr,
  // Observed state
  output logic      [20:0] pc_value,
  output logic      [4:0]  return_stack_pointer
);

  // --------------------------------------------------------------------
  // Register map on the plain port
  // --------------------------------------------------------------------
  // 0       low counter byte; bit zero always reads back as zero
  // 1       high latch, staged for the next low byte write
  // 2       upper latch, five bits; the top three read as zero
  // 3, 4, 5 top of stack low, high and upper
  // 6       return stack pointer, five bits
  // Writes and reads share one index; read data follow one cycle later.
  // Unmapped indices read as zero and ignore writes.
  // Only the top stack entry is kept here; deeper entries belong to the
  // core. The pointer wraps with no full flag, so software must watch it.

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [20:0] pc_ff,    nxt_pc;        // Program counter
  logic [7:0]  lath_ff,  nxt_lath;      // counter_high_latch
  logic [4:0]  latu_ff,  nxt_latu;      // counter_upper_latch
  logic [4:0]  sp_ff,    nxt_sp;        // Stack pointer
  logic [20:0] tos_ff,   nxt_tos;       // Top of stack value
  logic [7:0]  rdata_ff, nxt_rdata;     // Read data, one cycle later
  logic        wake_go;                 // Vectoring wake-up this cycle

  pcf_reg_req_t req;                    // Bundled register request
  pcf_seq_t     seq;                    // Bundled sequencing request

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign seq = '{branch: seq_branch, target: seq_target, advance: seq_advance};

  // Index decode for the low byte, the one write that moves the counter
  function automatic logic hit(input pcf_reg_req_t r, input logic [3:0] ofs);
    hit = (r.addr == ofs);
  endfunction : hit

  // Either enable lets an interrupt wake-up vector
  // The wake line is a pulse; the level enables are sampled beside it.
  assign wake_go = wake_int &&
                   (high_priority_global_int_enable || low_priority_global_int_enable);

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  // Priority: wake-up, then branch, then low-byte write, then advance.
  // A branch beats a computed jump in the same cycle, so the low byte
  // write is dropped then; the core is expected not to issue both.
  always_comb begin
    nxt_pc    = pc_ff;
    nxt_lath  = lath_ff;
    nxt_latu  = latu_ff;
    nxt_sp    = sp_ff;
    nxt_tos   = tos_ff;
    nxt_rdata = 8'h00;
    if (wake_go) begin
      nxt_pc  = wake_high ? PCF_HIGH_VEC : PCF_LOW_VEC;
      nxt_sp  = sp_ff + 5'h01;
      nxt_tos = pc_ff;
    end else if (seq.branch) begin
      // Latches deliberately untouched here
      nxt_pc = {seq.target[20:1], 1'b0};
    end else if (req.wr && hit(req, PCF_OFS_PC_LOW)) begin
      nxt_pc = {latu_ff, lath_ff, req.wdata[7:1], 1'b0};
    end else if (seq.advance) begin
      nxt_pc = pc_ff + PCF_STEP;
    end
    // Register writes other than the low byte
    if (req.wr) begin
      case (req.addr)
        PCF_OFS_LAT_HIGH: nxt_lath = req.wdata;
        PCF_OFS_LAT_UP:   nxt_latu = req.wdata[4:0];
        PCF_OFS_TOS_LOW:  if (!wake_go) nxt_tos[7:0]   = req.wdata;
        PCF_OFS_TOS_HIGH: if (!wake_go) nxt_tos[15:8]  = req.wdata;
        PCF_OFS_TOS_UP:   if (!wake_go) nxt_tos[20:16] = req.wdata[4:0];
        PCF_OFS_SP:       if (!wake_go) nxt_sp = req.wdata[4:0];
        default: ;
      endcase
    end
    // Reads; unmapped addresses answer zero
    if (req.rd) begin
      case (req.addr)
        PCF_OFS_PC_LOW: begin
          nxt_rdata = pc_ff[7:0];
          nxt_lath  = pc_ff[15:8];
          nxt_latu  = pc_ff[20:16];
        end
        PCF_OFS_LAT_HIGH: nxt_rdata = lath_ff;
        PCF_OFS_LAT_UP:   nxt_rdata = {3'b000, latu_ff};
        PCF_OFS_TOS_LOW:  nxt_rdata = tos_ff[7:0];
        PCF_OFS_TOS_HIGH: nxt_rdata = tos_ff[15:8];
        PCF_OFS_TOS_UP:   nxt_rdata = {3'b000, tos_ff[20:16]};
        PCF_OFS_SP:       nxt_rdata = {3'b000, sp_ff};
        default:          nxt_rdata = 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  // Latches reset too, so no unknown reaches the counter.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff    <= PCF_RESET_VEC;
      lath_ff  <= PCF_LAT_RST;
      latu_ff  <= PCF_LAT_RST[4:0];
      sp_ff    <= PCF_SP_RST;
      tos_ff   <= PCF_RESET_VEC;
      rdata_ff <= 8'h00;
    end else begin
      pc_ff    <= nxt_pc;
      lath_ff  <= nxt_lath;
      latu_ff  <= nxt_latu;
      sp_ff    <= nxt_sp;
      tos_ff   <= nxt_tos;
      rdata_ff <= nxt_rdata;
    end
  end

  // --------------------------------------------------------------------
  // Fetch path
  // --------------------------------------------------------------------
  // Separate bus: fetch runs alongside any register access.
  assign fetch_addr  = pc_ff;
  // Past the implemented end the word reads as zero, a no-op.
  // The limit is a parameter so one block serves every memory size.
  assign fetch_instr = (pc_ff < IMPL_LIMIT) ? prog_rdata : 16'h0000;

  assign reg_rdata            = rdata_ff;
  assign pc_value             = pc_ff;
  assign return_stack_pointer = sp_ff;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_lsb_zero;
    @(posedge clk) disable iff (!rst_n) pc_ff[0] == 1'b0;
  endproperty
  a_lsb_zero: assert property (p_lsb_zero) else $error("pc lsb set");

  property p_advance;
    @(posedge clk) disable iff (!rst_n)
      (seq_advance && !seq_branch && !wake_go && !reg_wr) |=> pc_ff == $past(pc_ff) + 21'h2;
  endproperty
  a_advance: assert property (p_advance) else $error("advance not by two");

  property p_branch;
    @(posedge clk) disable iff (!rst_n)
      (seq_branch && !wake_go) |=> pc_ff == {$past(seq_target[20:1]), 1'b0} && $stable(lath_ff);
  endproperty
  a_branch: assert property (p_branch) else $error("branch load wrong");

  property p_low_write;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == PCF_OFS_PC_LOW && !seq_branch && !wake_go)
      |=> pc_ff == {$past(latu_ff), $past(lath_ff), $past(reg_wdata[7:1]), 1'b0};
  endproperty
  a_low_write: assert property (p_low_write) else $error("latch copy failed");

  property p_low_read;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == PCF_OFS_PC_LOW)
      |=> lath_ff == $past(pc_ff[15:8]) && latu_ff == $past(pc_ff[20:16])
          && reg_rdata == $past(pc_ff[7:0]);
  endproperty
  a_low_read: assert property (p_low_read) else $error("latch capture failed");

  property p_wake_vec;
    @(posedge clk) disable iff (!rst_n)
      wake_go |=> pc_ff == ($past(wake_high) ? 21'h8 : 21'h18);
  endproperty
  a_wake_vec: assert property (p_wake_vec) else $error("wrong vector");

  property p_wake_push;
    @(posedge clk) disable iff (!rst_n)
      wake_go |=> tos_ff == $past(pc_ff) && sp_ff == $past(sp_ff) + 5'h1;
  endproperty
  a_wake_push: assert property (p_wake_push) else $error("push wrong");

  property p_beyond;
    @(posedge clk) disable iff (!rst_n) (pc_ff >= IMPL_LIMIT) |-> fetch_instr == 16'h0000;
  endproperty
  a_beyond: assert property (p_beyond) else $error("nonzero beyond end");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !(reg_wr || reg_rd) |=> $stable(lath_ff) && $stable(latu_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed");

  // Read data stand for one cycle only, then fall back to zero
  property p_rdata_idle;
    @(posedge clk) disable iff (!rst_n) !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

  // A latch write stages a value; a low byte read in the same cycle wins
  property p_lath_write;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && !reg_rd && reg_addr == PCF_OFS_LAT_HIGH) |=> lath_ff == $past(reg_wdata);
  endproperty
  a_lath_write: assert property (p_lath_write) else $error("high latch lost");

  property p_latu_write;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && !reg_rd && reg_addr == PCF_OFS_LAT_UP) |=> latu_ff == $past(reg_wdata[4:0]);
  endproperty
  a_latu_write: assert property (p_latu_write) else $error("upper latch lost");

  // Software stack writes land only when no wake-up owns the stack
  property p_sp_write;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == PCF_OFS_SP && !wake_go) |=> sp_ff == $past(reg_wdata[4:0]);
  endproperty
  a_sp_write: assert property (p_sp_write) else $error("pointer write lost");

  property p_tos_write;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == PCF_OFS_TOS_LOW && !wake_go) |=> tos_ff[7:0] == $past(reg_wdata);
  endproperty
  a_tos_write: assert property (p_tos_write) else $error("stack write lost");

  // A wake event with both enables clear must leave the pointer alone
  property p_no_vector;
    @(posedge clk) disable iff (!rst_n)
      (wake_int && !wake_go && !(reg_wr && reg_addr == PCF_OFS_SP)) |=> $stable(sp_ff);
  endproperty
  a_no_vector: assert property (p_no_vector) else $error("stack moved");

  // --------------------------------------------------------------------
  // Coverage of the main scenarios
  // --------------------------------------------------------------------
  c_wake:   cover property (@(posedge clk) disable iff (!rst_n) wake_go);
  // Branch followed straight away by a sequential step
  c_branch: cover property (@(posedge clk) disable iff (!rst_n) seq_branch ##1 seq_advance);
  // Computed jump: read the low byte, write it back the next cycle
  c_comp:   cover property (@(posedge clk) disable iff (!rst_n)
                            reg_rd && reg_addr == PCF_OFS_PC_LOW ##1
                            reg_wr && reg_addr == PCF_OFS_PC_LOW);
  c_low_vec: cover property (@(posedge clk) disable iff (!rst_n) wake_go && !wake_high);
  // Fetch past the implemented end, where only no-ops come back
  c_beyond:  cover property (@(posedge clk) disable iff (!rst_n) pc_ff >= IMPL_LIMIT);

endmodule : pcf_core

`default_nettype wire

// file: dv/pcf_prog_mem.sv
/*
  Program memory model on the fetch bus of the program counter block.
  Assumes a combinational read of one 16-bit word for each fetch address.
*/
`timescale 1ns/100ps
`default_nettype none

module pcf_prog_mem (
  // Fetch bus
  input  wire logic [20:0] fetch_addr,
  output logic      [15:0] prog_rdata
);
  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  // The pattern is never all zeros, so a forced no-op fetch stands out
  assign prog_rdata = {~fetch_addr[8:1], fetch_addr[8:1]};
endmodule : pcf_prog_mem

`default_nettype wire

// file: dv/pcf_core_tb.sv
/*
  Self-checking testbench for pcf_core with the program memory model.
  Assumes pcf_pkg, pcf_core and pcf_prog_mem are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module pcf_core_tb;
  import pcf_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  localparam logic [20:0] LIMIT = 21'h00_0100; // Small memory, so the edge is reachable
  logic        clk, rst_n, reg_wr, reg_rd;      // Clock, reset, strobes
  logic [3:0]  reg_addr;                        // Register index
  logic [7:0]  reg_wdata, reg_rdata, d;         // Register data
  logic        adv, br, wk, wh, eh, el;         // Sequencing and wake controls
  logic [20:0] tgt, fetch_addr, pc_value;       // Target and counter views
  logic [15:0] prog_rdata, fetch_instr;         // Fetch bus words
  logic [4:0]  sp;                              // Stack pointer view
  int          n_fail, n_checks, cyc;           // Counters

  pcf_core #(.IMPL_LIMIT(LIMIT)) u_pcf_core (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .seq_advance(adv), .seq_branch(br), .seq_target(tgt),
    .wake_int(wk), .wake_high(wh), .high_priority_global_int_enable(eh),
    .low_priority_global_int_enable(el), .fetch_addr(fetch_addr),
    .prog_rdata(prog_rdata), .fetch_instr(fetch_instr),
    .pc_value(pc_value), .return_stack_pointer(sp));

  pcf_prog_mem u_pcf_prog_mem (.fetch_addr(fetch_addr), .prog_rdata(prog_rdata));

  // ------------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A hang is cut short well above the fewer than a hundred cycles the run needs
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe, released on the edge that takes it
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask : rd

  // One cycle of core sequencing, then settle
  task ctl(input logic a, b, w, h, e, l, input logic [20:0] t);
    @(posedge clk);
    adv <= a;
    br  <= b;
    wk  <= w;
    wh  <= h;
    eh  <= e;
    el  <= l;
    tgt <= t;
    @(posedge clk);
    adv <= 1'b0;
    br  <= 1'b0;
    wk  <= 1'b0;
    @(negedge clk);
  endtask : ctl

  task results();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_reset();
    @(negedge clk);
    chk(pc_value, 0);
    chk(sp, 0);
    chk(fetch_addr, PCF_RESET_VEC);
    chk(reg_rdata, 0);
  endtask : t_reset

  task t_advance();
    repeat (3) ctl(1, 0, 0, 0, 0, 0, 0);
    chk(pc_value, 3 * PCF_STEP);
  endtask : t_advance

  // Odd data into the low byte drags both latches in and drops bit zero
  task t_latch();
    wr(PCF_OFS_LAT_HIGH, 8'h12);
    wr(PCF_OFS_LAT_UP, 8'h1F);
    wr(PCF_OFS_PC_LOW, 8'h35);
    @(negedge clk);
    chk(pc_value, 21'h1F_1234);
    rd(PCF_OFS_PC_LOW, d);
    chk(d, 8'h34);
  endtask : t_latch

  // Latches still hold 12/1F, so a branch that used them would show
  task t_branch();
    ctl(0, 1, 0, 0, 0, 0, 21'h0A_BCDF);
    chk(pc_value, 21'h0A_BCDE);
    chk(fetch_instr, 0);
    rd(PCF_OFS_PC_LOW, d);
    chk(d, 8'hDE);
    rd(PCF_OFS_LAT_HIGH, d);
    chk(d, 8'hBC);
    rd(PCF_OFS_LAT_UP, d);
    chk(d, 8'h0A);
    rd(4'hF, d);
    chk(d, 0);
  endtask : t_branch

  task t_wake();
    ctl(0, 0, 1, 1, 1, 0, 0);
    chk(pc_value, PCF_HIGH_VEC);
    chk(sp, 5'h01);
    rd(PCF_OFS_TOS_LOW, d);
    chk(d, 8'hDE);
    rd(PCF_OFS_TOS_HIGH, d);
    chk(d, 8'hBC);
    rd(PCF_OFS_TOS_UP, d);
    chk(d, 8'h0A);
    ctl(1, 0, 0, 0, 0, 0, 0);
    chk(fetch_instr, 16'hFA05);
    ctl(0, 0, 1, 0, 0, 1, 0);
    chk(pc_value, PCF_LOW_VEC);
    chk(sp, 5'h02);
    rd(PCF_OFS_TOS_LOW, d);
    chk(d, 8'h0A);
    // Both enables clear: the wake must leave counter and stack alone
    ctl(0, 0, 1, 1, 0, 0, 0);
    chk(pc_value, PCF_LOW_VEC);
    chk(sp, 5'h02);
  endtask : t_wake

  // Stack registers take software writes; read data fall back after one cycle
  task t_regs();
    wr(PCF_OFS_TOS_LOW, 8'h5A);
    wr(PCF_OFS_TOS_HIGH, 8'hC3);
    wr(PCF_OFS_TOS_UP, 8'hFF);
    wr(PCF_OFS_SP, 8'hE9);
    @(negedge clk);
    chk(sp, 5'h09);
    rd(PCF_OFS_TOS_UP, d);
    chk(d, 8'h1F);
    @(negedge clk);
    chk(reg_rdata, 0);
    rd(PCF_OFS_TOS_HIGH, d);
    chk(d, 8'hC3);
    rd(PCF_OFS_TOS_LOW, d);
    chk(d, 8'h5A);
    rd(PCF_OFS_SP, d);
    chk(d, 8'h09);
  endtask : t_regs

  // Computed jump with no gap: the read clears the stale latches first
  task t_comp();
    @(posedge clk);
    reg_addr <= PCF_OFS_PC_LOW;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b1;
    reg_wdata <= 8'h41;
    @(negedge clk);
    chk(reg_rdata, 8'h18);
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
    chk(pc_value, 21'h00_0040);
    chk(fetch_addr, 21'h00_0040);
    chk(fetch_instr, 16'hDF20);
  endtask : t_comp

  // Reset in mid-run: counter and pointer restart, latches clear
  task t_rereset();
    wr(PCF_OFS_LAT_HIGH, 8'h77);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(pc_value, PCF_RESET_VEC);
    chk(sp, 0);
    rd(PCF_OFS_LAT_HIGH, d);
    chk(d, PCF_LAT_RST);
    ctl(1, 0, 0, 0, 0, 0, 0);
    chk(pc_value, PCF_STEP);
  endtask : t_rereset

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    n_fail = 0;
    n_checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, adv, br, wk, wh, eh, el} = 8'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    tgt = 21'h00_0000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_advance();
    t_latch();
    t_branch();
    t_wake();
    t_regs();
    t_comp();
    t_rereset();
    results();
  end
endmodule : pcf_core_tb

`default_nettype wire
